// ---- core/scr_pkg.sv ----
// Notes on behaviour
// - Registers 02h-06h read/write via data port when key is 89h and index matches.
// - In extension adapter mode the adapter base register is the adapter's base address.
// - Writing adapter base drives both adapter strobes low and base onto adapter data.
// - After latching, host reads or writes at that base pulse the matching adapter strobe.
// - In DMA, host read or write with adapter DMA acknowledge asserts the matching strobe.
// - MIDI bits pick divide by 12 when set, 13 when clear; bit 0 second unit.
// - Extra base bit 2 set decodes second serial unit at 3F8h, else register one.
// - Extra base bit 3 set decodes first serial unit at 2F8h, else register one.
// - Select bit 4 at 0 gives portable enables on shared pins, at 1 game strobes.
// - EPP revision bit selects revision 1.9 at 0 and 1.7 at 1; 1.7 default.
// - Game port disable bit 6 disables the game port when set.
// - Legacy mode bit 7 disables bidirectional data; strap high lets control bit steer.
// - Power bits 7:4 power down parallel, game, first serial, second serial units.
// - Bits 3:0 tri-state those units' outputs while powered down, same order.
// - Low nibble of register 05h is the ECP FIFO threshold, reset to zero.
// - Register 06h bit 6 is the high oscillator bit, joined with register zero's two.
// - Two-drive mode: select and motor A or B low for drive 0 or 1 with motor.
// - Four-drive mode: selects always encode drive; both motors low when its motor is set.
// - Pull-up control bit 4 enables floppy input pull-ups at 0, disables at 1.
// - Bits 3 and 2 power down the floppy controller and disk interface.
// - Bits 1 and 0 tri-state floppy and disk interface outputs while powered down.
// - Extension adapter mode is parallel mode bits 10 with extra mode bit 0.
// - Lock bit set blocks all configuration register reads and writes.
package scr_pkg;

  // Host port addresses of the configuration access window and the game port.
  localparam logic [9:0] KEY_PORT = 10'h250;
  localparam logic [9:0] INDEX_PORT = 10'h251;
  localparam logic [9:0] DATA_PORT = 10'h252;
  localparam logic [9:0] GAME_PORT = 10'h201;
  localparam logic [7:0] KEY_VALUE = 8'h89;

  // Register indices and bank layout.
  localparam logic [7:0] IDX_FIRST = 8'h02;
  localparam logic [7:0] IDX_LAST = 8'h06;
  localparam int unsigned NUM_REGS = 5;
  localparam logic [7:0] RST_VALS [NUM_REGS] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] WR_MASKS [NUM_REGS] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h7f};
  localparam logic [2:0] OFS_ADP = 3'h0;
  localparam logic [2:0] OFS_SER = 3'h1;
  localparam logic [2:0] OFS_PWR = 3'h2;
  localparam logic [2:0] OFS_FIFO = 3'h3;
  localparam logic [2:0] OFS_DRV = 3'h4;

  // Field positions.
  localparam int unsigned BIT_CEA = 0;
  localparam int unsigned BIT_MIDI_B = 0;
  localparam int unsigned BIT_MIDI_A = 1;
  localparam int unsigned BIT_XBASE_B = 2;
  localparam int unsigned BIT_XBASE_A = 3;
  localparam int unsigned BIT_PORT_SEL = 4;
  localparam int unsigned BIT_EPP_REV = 5;
  localparam int unsigned BIT_GAME_DIS = 6;
  localparam int unsigned BIT_BIDIR_DIS = 7;
  localparam int unsigned BIT_OSC_HI = 6;
  localparam int unsigned BIT_FOUR_DRV = 5;
  localparam int unsigned BIT_PULL_DIS = 4;
  localparam int unsigned BIT_FDC_PWD = 3;
  localparam int unsigned BIT_IDE_PWD = 2;
  localparam int unsigned BIT_FDC_TRI = 1;
  localparam int unsigned BIT_IDE_TRI = 0;
  localparam int unsigned DOR_MOTOR_A = 4;
  localparam int unsigned DOR_MOTOR_B = 5;

  // Serial unit bases.
  localparam logic [9:0] SER_A_FORCED = 10'h2f8;
  localparam logic [9:0] SER_B_FORCED = 10'h3f8;
  localparam logic [9:0] SER_A_TABLE [3] = '{10'h2e8, 10'h3e8, 10'h3f8};
  localparam logic [9:0] SER_B_TABLE [3] = '{10'h3e8, 10'h2e8, 10'h2f8};
  localparam logic [1:0] SER_SEL_OFF = 2'h3;

  // Parallel mode codes {extra bit, two low bits}.
  localparam logic [2:0] PRT_MODE_LEGACY = 3'h0;
  localparam logic [2:0] PRT_MODE_ADAPTER = 3'h2;

  // Serial clock divide ratios.
  localparam logic [3:0] DIV_MIDI = 4'hc;
  localparam logic [3:0] DIV_STD = 4'hd;

  // Adapter base latch pulse.
  localparam int unsigned CORE_CLK_PERIOD_NS = 10;
  localparam int unsigned ADP_LATCH_TIME_NS = 100;
  localparam logic [3:0] ADP_LATCH_CYC =
    4'((ADP_LATCH_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS);

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic rd_n;
    logic wr_n;
    logic aen;
  } scr_host_req_t;

  typedef struct packed {
    logic mo_b_n;
    logic mo_a_n;
    logic ds_b_n;
    logic ds_a_n;
  } scr_drive_pins_t;

  typedef enum logic {ADP_IDLE, ADP_LATCH} scr_adp_state_t;

endpackage : scr_pkg

// ---- core/scr_clkdiv.sv ----
`timescale 1ns/10ps
module scr_clkdiv (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Ratio select and divided clock.
  input wire logic midi,
  output logic clk_out
);

  logic [3:0] cnt_r;
  logic [3:0] ratio;
  logic [3:0] cnt_nxt;

  assign ratio = midi ? scr_pkg::DIV_MIDI : scr_pkg::DIV_STD;
  // A ratio change applies to the cycle in progress: it wraps at the new ratio, or on the next clock if already past it.
  assign cnt_nxt = (cnt_r >= ratio - 4'h1) ? 4'h0 : cnt_r + 4'h1;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      clk_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_out <= (cnt_nxt < {1'b0, ratio[3:1]});
    end
  end

endmodule : scr_clkdiv

// ---- core/scr_drive_enc.sv ----
`timescale 1ns/10ps
module scr_drive_enc (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Mode and digital output register.
  input wire logic four_mode,
  input wire logic [7:0] dor,
  output scr_pkg::scr_drive_pins_t pins
);

  logic [1:0] drv;
  logic motor_on;
  scr_pkg::scr_drive_pins_t two_pins;
  scr_pkg::scr_drive_pins_t four_pins;

  assign drv = dor[1:0];
  assign motor_on = dor[scr_pkg::DOR_MOTOR_A + 32'(drv)];
  assign two_pins.ds_a_n = ~(drv == 2'h0 && dor[scr_pkg::DOR_MOTOR_A]);
  assign two_pins.mo_a_n = ~(drv == 2'h0 && dor[scr_pkg::DOR_MOTOR_A]);
  assign two_pins.ds_b_n = ~(drv == 2'h1 && dor[scr_pkg::DOR_MOTOR_B]);
  assign two_pins.mo_b_n = ~(drv == 2'h1 && dor[scr_pkg::DOR_MOTOR_B]);
  assign four_pins.mo_a_n = ~motor_on;
  assign four_pins.mo_b_n = ~motor_on;
  assign four_pins.ds_a_n = drv[0];
  assign four_pins.ds_b_n = drv[1];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins <= '1;
    end else begin
      pins <= four_mode ? four_pins : two_pins;
    end
  end

endmodule : scr_drive_enc

// ---- core/scr_cfg_bank.sv ----
`timescale 1ns/10ps
module scr_cfg_bank (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Host I/O bus.
  input scr_pkg::scr_host_req_t HOST,
  output logic [7:0] SD_OUT,
  output logic SD_OE,
  // Fields held in the other configuration registers.
  input wire logic [1:0] PRT_MODE_LO,
  input wire logic PRT_MODE_HI,
  input wire logic CONFIG_LOCK_BIT,
  input wire logic [1:0] OSC_CTRL_LO,
  input wire logic [1:0] FIRST_SERIAL_SEL,
  input wire logic [1:0] SECOND_SERIAL_SEL,
  // External adapter on the parallel pins.
  input wire logic ADAPTER_DMA_ACK_N,
  output logic ADAPTER_READ_STROBE_N,
  output logic ADAPTER_WRITE_STROBE_N,
  output logic [6:0] ADAPTER_DATA_PINS_OUT,
  output logic ADAPTER_DATA_PINS_OE,
  output logic EXTERNAL_ADAPTER_MODE,
  // Serial units.
  output logic [1:0] SERIAL_CLK_OUT,
  output logic [9:0] FIRST_SERIAL_BASE,
  output logic FIRST_SERIAL_EN,
  output logic [9:0] SECOND_SERIAL_BASE,
  output logic SECOND_SERIAL_EN,
  // Shared game and portable pins.
  input wire logic PORTABLE_FLOPPY_ENABLE_IN,
  input wire logic PORTABLE_EXTERNAL_ENABLE_IN,
  output logic SHARED_PIN_41,
  output logic SHARED_PIN_39,
  output logic GAME_PORT_DISABLE,
  // Parallel port.
  input wire logic PARALLEL_DIRECTION_STRAP,
  input wire logic PRINTER_CTRL_DIR,
  output logic EPP_REVISION_SELECT,
  output logic PARALLEL_BIDIR_EN,
  output logic PARALLEL_DIR_INPUT,
  output logic [3:0] ECP_FIFO_THRESHOLD,
  // Unit power, order parallel, game, first serial, second serial.
  output logic [3:0] UNIT_POWER_DOWN,
  output logic [3:0] UNIT_FLOAT,
  output logic [2:0] OSC_SELECT,
  // Floppy and disk interface.
  input wire logic [7:0] FLOPPY_DOR,
  output logic DRIVE_SELECT_OUT_A_N,
  output logic DRIVE_SELECT_OUT_B_N,
  output logic MOTOR_OUT_A_N,
  output logic MOTOR_OUT_B_N,
  output logic FLOPPY_PULLUP_EN,
  output logic FLOPPY_CTRL_POWER_DOWN,
  output logic DISK_IFACE_POWER_DOWN,
  output logic FLOPPY_CTRL_FLOAT,
  output logic DISK_IFACE_FLOAT
);

  // Host access decode.
  logic wr_prev_r;
  logic [7:0] key_r;
  logic [7:0] index_r;
  logic [7:0] cfg_r [scr_pkg::NUM_REGS];
  wire cpu_io = ~HOST.aen;
  wire wr_start = ~HOST.wr_n & wr_prev_r;
  wire key_hit = cpu_io && HOST.addr == scr_pkg::KEY_PORT;
  wire index_hit = cpu_io && HOST.addr == scr_pkg::INDEX_PORT;
  wire data_hit = cpu_io && HOST.addr == scr_pkg::DATA_PORT;
  wire unlocked = key_r == scr_pkg::KEY_VALUE;
  // The lock bit gates both directions; the key can still be written to close the window.
  wire index_ok = unlocked & ~CONFIG_LOCK_BIT;
  wire in_range = index_r >= scr_pkg::IDX_FIRST && index_r <= scr_pkg::IDX_LAST;
  wire reg_ok = index_ok & in_range;
  wire [2:0] reg_ofs = 3'(index_r - scr_pkg::IDX_FIRST);
  wire key_wr = wr_start & key_hit;
  wire index_wr = wr_start & index_hit & index_ok;
  wire data_wr = wr_start & data_hit & reg_ok;
  wire rd_data = data_hit & reg_ok;
  wire rd_index = index_hit & index_ok;
  wire [7:0] rdata_nxt = rd_data ? cfg_r[reg_ofs] : (rd_index ? index_r : 8'h00);

  // Named views of the bank.
  wire [7:0] ext_adapter_base = cfg_r[scr_pkg::OFS_ADP];
  wire [7:0] serial_game_parallel_config = cfg_r[scr_pkg::OFS_SER];
  wire [7:0] unit_power_tristate_ctrl = cfg_r[scr_pkg::OFS_PWR];
  wire [7:0] ecp_fifo_threshold = cfg_r[scr_pkg::OFS_FIFO];
  wire [7:0] floppy_ide_power_config = cfg_r[scr_pkg::OFS_DRV];

  assign SD_OE = ~HOST.rd_n & (rd_data | rd_index);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_prev_r <= 1'b1;
      key_r <= 8'h00;
      index_r <= 8'h00;
      SD_OUT <= 8'h00;
    end else begin
      wr_prev_r <= HOST.wr_n;
      SD_OUT <= rdata_nxt;
      if (key_wr) begin
        key_r <= HOST.wdata;
      end
      if (index_wr) begin
        index_r <= HOST.wdata;
      end
    end
  end

  // Each register stores only its implemented bits, so reserved bits read zero.
  genvar gi;
  generate
    for (gi = 0; gi < scr_pkg::NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
          cfg_r[gi] <= scr_pkg::RST_VALS[gi];
        end else if (data_wr && reg_ofs == 3'(gi)) begin
          cfg_r[gi] <= HOST.wdata & scr_pkg::WR_MASKS[gi];
        end
      end
    end
  endgenerate

  // External adapter.
  scr_pkg::scr_adp_state_t adp_state_r;
  scr_pkg::scr_adp_state_t adp_state_nxt;
  logic [3:0] latch_cnt_r;
  logic [3:0] latch_cnt_nxt;
  wire adapter_mode = {PRT_MODE_HI, PRT_MODE_LO} == scr_pkg::PRT_MODE_ADAPTER;
  wire base_wr = data_wr && reg_ofs == scr_pkg::OFS_ADP;
  wire latching = adp_state_r == scr_pkg::ADP_LATCH;
  wire coarse_compare_bit = ext_adapter_base[scr_pkg::BIT_CEA];
  wire [6:0] stored_adapter_base_bits = ext_adapter_base[7:1];
  wire addr_match = coarse_compare_bit ?
    HOST.addr[9:4] == stored_adapter_base_bits[6:1] :
    HOST.addr[9:3] == stored_adapter_base_bits;
  wire dma_ack = ~ADAPTER_DMA_ACK_N;
  wire adp_sel = adapter_mode & ~latching & ((cpu_io & addr_match) | dma_ack);
  wire adp_rd = adp_sel & ~HOST.rd_n;
  wire adp_wr = adp_sel & ~HOST.wr_n;

  always_comb begin
    adp_state_nxt = adp_state_r;
    latch_cnt_nxt = latch_cnt_r;
    unique case (adp_state_r)
      scr_pkg::ADP_IDLE: begin
        if (base_wr && adapter_mode) begin
          adp_state_nxt = scr_pkg::ADP_LATCH;
          latch_cnt_nxt = scr_pkg::ADP_LATCH_CYC;
        end
      end
      scr_pkg::ADP_LATCH: begin
        latch_cnt_nxt = latch_cnt_r - 4'h1;
        if (latch_cnt_r == 4'h1) begin
          adp_state_nxt = scr_pkg::ADP_IDLE;
        end
      end
    endcase
  end

  // Strobes are registered so that address decode glitches never reach the adapter.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      adp_state_r <= scr_pkg::ADP_IDLE;
      latch_cnt_r <= 4'h0;
      ADAPTER_READ_STROBE_N <= 1'b1;
      ADAPTER_WRITE_STROBE_N <= 1'b1;
      ADAPTER_DATA_PINS_OUT <= 7'h00;
      ADAPTER_DATA_PINS_OE <= 1'b0;
    end else begin
      adp_state_r <= adp_state_nxt;
      latch_cnt_r <= latch_cnt_nxt;
      ADAPTER_READ_STROBE_N <= ~((adp_state_nxt == scr_pkg::ADP_LATCH) | adp_rd);
      ADAPTER_WRITE_STROBE_N <= ~((adp_state_nxt == scr_pkg::ADP_LATCH) | adp_wr);
      ADAPTER_DATA_PINS_OUT <= base_wr ? HOST.wdata[7:1] : stored_adapter_base_bits;
      ADAPTER_DATA_PINS_OE <= adp_state_nxt == scr_pkg::ADP_LATCH;
    end
  end

  assign EXTERNAL_ADAPTER_MODE = adapter_mode;

  // Serial clocks: index 0 is the second unit, index 1 the first.
  wire [1:0] midi_bits = {serial_game_parallel_config[scr_pkg::BIT_MIDI_A],
                          serial_game_parallel_config[scr_pkg::BIT_MIDI_B]};
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ser_clk
      scr_clkdiv u_div (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .midi(midi_bits[gi]),
        .clk_out(SERIAL_CLK_OUT[gi])
      );
    end
  endgenerate

  // Serial bases.
  wire first_serial_extra_base = serial_game_parallel_config[scr_pkg::BIT_XBASE_A];
  wire second_serial_extra_base = serial_game_parallel_config[scr_pkg::BIT_XBASE_B];
  wire first_off = FIRST_SERIAL_SEL == scr_pkg::SER_SEL_OFF;
  wire second_off = SECOND_SERIAL_SEL == scr_pkg::SER_SEL_OFF;
  assign FIRST_SERIAL_BASE = first_serial_extra_base ? scr_pkg::SER_A_FORCED :
    (first_off ? 10'h000 : scr_pkg::SER_A_TABLE[FIRST_SERIAL_SEL]);
  assign FIRST_SERIAL_EN = first_serial_extra_base | ~first_off;
  assign SECOND_SERIAL_BASE = second_serial_extra_base ? scr_pkg::SER_B_FORCED :
    (second_off ? 10'h000 : scr_pkg::SER_B_TABLE[SECOND_SERIAL_SEL]);
  assign SECOND_SERIAL_EN = second_serial_extra_base | ~second_off;

  // Game port and shared pins.
  wire adapter_portable_select = serial_game_parallel_config[scr_pkg::BIT_PORT_SEL];
  wire game_port_disable = serial_game_parallel_config[scr_pkg::BIT_GAME_DIS];
  wire game_hit = cpu_io && HOST.addr == scr_pkg::GAME_PORT && !game_port_disable &&
    !UNIT_POWER_DOWN[2];
  wire game_read_strobe_n = ~(game_hit & ~HOST.rd_n);
  wire game_write_strobe_n = ~(game_hit & ~HOST.wr_n);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      SHARED_PIN_41 <= 1'b1;
      SHARED_PIN_39 <= 1'b1;
    end else begin
      SHARED_PIN_41 <= adapter_portable_select ? game_read_strobe_n :
        PORTABLE_FLOPPY_ENABLE_IN;
      SHARED_PIN_39 <= adapter_portable_select ? game_write_strobe_n :
        PORTABLE_EXTERNAL_ENABLE_IN;
    end
  end

  assign GAME_PORT_DISABLE = game_port_disable;

  // Parallel port.
  wire legacy_mode = {PRT_MODE_HI, PRT_MODE_LO} == scr_pkg::PRT_MODE_LEGACY;
  assign EPP_REVISION_SELECT = serial_game_parallel_config[scr_pkg::BIT_EPP_REV];
  assign PARALLEL_BIDIR_EN = legacy_mode &
    ~serial_game_parallel_config[scr_pkg::BIT_BIDIR_DIS];
  assign PARALLEL_DIR_INPUT = PARALLEL_BIDIR_EN & PARALLEL_DIRECTION_STRAP &
    PRINTER_CTRL_DIR;
  assign ECP_FIFO_THRESHOLD = ecp_fifo_threshold[3:0];

  // Unit power and float.
  assign UNIT_POWER_DOWN = unit_power_tristate_ctrl[7:4];
  assign UNIT_FLOAT = unit_power_tristate_ctrl[7:4] & unit_power_tristate_ctrl[3:0];
  assign OSC_SELECT = {floppy_ide_power_config[scr_pkg::BIT_OSC_HI], OSC_CTRL_LO};

  // Floppy and disk interface.
  scr_pkg::scr_drive_pins_t drive_pins;
  scr_drive_enc u_drive (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .four_mode(floppy_ide_power_config[scr_pkg::BIT_FOUR_DRV]),
    .dor(FLOPPY_DOR),
    .pins(drive_pins)
  );
  assign DRIVE_SELECT_OUT_A_N = drive_pins.ds_a_n;
  assign DRIVE_SELECT_OUT_B_N = drive_pins.ds_b_n;
  assign MOTOR_OUT_A_N = drive_pins.mo_a_n;
  assign MOTOR_OUT_B_N = drive_pins.mo_b_n;
  assign FLOPPY_PULLUP_EN = ~floppy_ide_power_config[scr_pkg::BIT_PULL_DIS];
  assign FLOPPY_CTRL_POWER_DOWN = floppy_ide_power_config[scr_pkg::BIT_FDC_PWD];
  assign DISK_IFACE_POWER_DOWN = floppy_ide_power_config[scr_pkg::BIT_IDE_PWD];
  assign FLOPPY_CTRL_FLOAT = FLOPPY_CTRL_POWER_DOWN &
    floppy_ide_power_config[scr_pkg::BIT_FDC_TRI];
  assign DISK_IFACE_FLOAT = DISK_IFACE_POWER_DOWN &
    floppy_ide_power_config[scr_pkg::BIT_IDE_TRI];

endmodule : scr_cfg_bank

// ---- test/scr_cfg_bank_props.sv ----
`timescale 1ns/10ps
module scr_cfg_bank_props (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Host side.
  input scr_pkg::scr_host_req_t HOST,
  input wire logic SD_OE,
  input wire logic CONFIG_LOCK_BIT,
  input wire logic [1:0] OSC_CTRL_LO,
  // Adapter side.
  input wire logic ADAPTER_DMA_ACK_N,
  input wire logic ADAPTER_READ_STROBE_N,
  input wire logic ADAPTER_WRITE_STROBE_N,
  input wire logic ADAPTER_DATA_PINS_OE,
  input wire logic EXTERNAL_ADAPTER_MODE,
  // Unit control.
  input wire logic [3:0] UNIT_POWER_DOWN,
  input wire logic [3:0] UNIT_FLOAT,
  input wire logic [2:0] OSC_SELECT,
  input wire logic [7:0] FLOPPY_DOR,
  input wire logic MOTOR_OUT_A_N,
  input wire logic MOTOR_OUT_B_N,
  input wire logic FLOPPY_CTRL_FLOAT,
  input wire logic FLOPPY_CTRL_POWER_DOWN
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  wire logic adp_idle = EXTERNAL_ADAPTER_MODE && !ADAPTER_DATA_PINS_OE;

  a_latch_strobes: assert property (
    ADAPTER_DATA_PINS_OE |-> !ADAPTER_READ_STROBE_N && !ADAPTER_WRITE_STROBE_N)
    else $error("adapter strobes not both low while base is presented");
  a_latch_length: assert property (
    $rose(ADAPTER_DATA_PINS_OE) |-> ADAPTER_DATA_PINS_OE[*8] ##1 ADAPTER_DATA_PINS_OE[*2]
    ##1 !ADAPTER_DATA_PINS_OE) else $error("base latch window has wrong length");
  a_dma_read: assert property (
    adp_idle && !ADAPTER_DMA_ACK_N && !HOST.rd_n |=> !ADAPTER_READ_STROBE_N)
    else $error("dma read gave no adapter read strobe");
  a_dma_write: assert property (
    adp_idle && !ADAPTER_DMA_ACK_N && !HOST.wr_n |=> !ADAPTER_WRITE_STROBE_N)
    else $error("dma write gave no adapter write strobe");
  a_mode_quiet: assert property (
    !EXTERNAL_ADAPTER_MODE && !$past(EXTERNAL_ADAPTER_MODE) |->
    ADAPTER_READ_STROBE_N && ADAPTER_WRITE_STROBE_N) else $error("strobe outside adapter mode");
  a_motor_idle: assert property (
    FLOPPY_DOR[7:4] == 4'h0 |=> MOTOR_OUT_A_N && MOTOR_OUT_B_N)
    else $error("motor output low with no motor bit");
  a_osc_join: assert property (
    OSC_SELECT[1:0] == OSC_CTRL_LO) else $error("oscillator select low bits wrong");
  a_unit_float: assert property (
    (UNIT_FLOAT & ~UNIT_POWER_DOWN) == 4'h0) else $error("powered unit floated");
  a_fdc_float: assert property (
    FLOPPY_CTRL_FLOAT |-> FLOPPY_CTRL_POWER_DOWN) else $error("powered floppy floated");
  a_read_oe: assert property (
    SD_OE |-> !HOST.rd_n && HOST.addr != scr_pkg::KEY_PORT) else $error("data driven off read");
  a_lock_silent: assert property (
    CONFIG_LOCK_BIT && HOST.addr == scr_pkg::DATA_PORT |-> !SD_OE)
    else $error("locked data port answered");
endmodule : scr_cfg_bank_props

bind scr_cfg_bank scr_cfg_bank_props u_props (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HOST(HOST),
  .SD_OE(SD_OE), .CONFIG_LOCK_BIT(CONFIG_LOCK_BIT), .OSC_CTRL_LO(OSC_CTRL_LO),
  .ADAPTER_DMA_ACK_N(ADAPTER_DMA_ACK_N), .ADAPTER_READ_STROBE_N(ADAPTER_READ_STROBE_N),
  .ADAPTER_WRITE_STROBE_N(ADAPTER_WRITE_STROBE_N), .ADAPTER_DATA_PINS_OE(ADAPTER_DATA_PINS_OE),
  .EXTERNAL_ADAPTER_MODE(EXTERNAL_ADAPTER_MODE), .UNIT_POWER_DOWN(UNIT_POWER_DOWN),
  .UNIT_FLOAT(UNIT_FLOAT), .OSC_SELECT(OSC_SELECT), .FLOPPY_DOR(FLOPPY_DOR),
  .MOTOR_OUT_A_N(MOTOR_OUT_A_N), .MOTOR_OUT_B_N(MOTOR_OUT_B_N),
  .FLOPPY_CTRL_FLOAT(FLOPPY_CTRL_FLOAT), .FLOPPY_CTRL_POWER_DOWN(FLOPPY_CTRL_POWER_DOWN));

// ---- test/scr_host_model.sv ----
`timescale 1ns/10ps
module scr_host_model (
  // Clock.
  input wire logic CORE_CLK,
  // Bus toward the device.
  output scr_pkg::scr_host_req_t HOST,
  input wire logic [7:0] SD_OUT,
  input wire logic SD_OE
);
  initial HOST = '{addr: 10'h000, wdata: 8'h00, rd_n: 1'b1, wr_n: 1'b1, aen: 1'b0};

  // The data lines are inverted after each cycle so stale write data can never look valid.
  task automatic io(input logic [9:0] a, input logic [7:0] d, input logic rd, input logic dma,
                    output logic [7:0] q, output logic oe);
    @(posedge CORE_CLK);
    HOST <= '{addr: a, wdata: d, rd_n: !rd, wr_n: rd, aen: dma};
    @(posedge CORE_CLK);
    #1;
    q = SD_OUT;
    oe = SD_OE;
    @(posedge CORE_CLK);
    HOST <= '{addr: 10'h000, wdata: ~d, rd_n: 1'b1, wr_n: 1'b1, aen: 1'b0};
  endtask : io

  task automatic cfg(input logic [7:0] idx, input logic [7:0] d, input logic rd,
                     output logic [7:0] q, output logic oe);
    logic [7:0] j;
    logic k;
    io(scr_pkg::KEY_PORT, scr_pkg::KEY_VALUE, 1'b0, 1'b0, j, k);
    io(scr_pkg::INDEX_PORT, idx, 1'b0, 1'b0, j, k);
    io(scr_pkg::DATA_PORT, d, rd, 1'b0, q, oe);
  endtask : cfg
endmodule : scr_host_model

// ---- test/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  scr_pkg::scr_host_req_t host;
  logic [7:0] sd_out, q;
  logic sd_oe, oe, lock = 1'b0, mode_hi = 1'b0, dack_n = 1'b1, pfd = 1'b0, pext = 1'b0;
  logic [1:0] mode_lo = 2'h0, osc = 2'h0, sel_a = 2'h0, sel_b = 2'h0, sclk, sclk_q = 2'h0;
  logic [7:0] dor = 8'h00;
  logic rs_n, ws_n, dpoe, xmode, gdis, epp, bidir, pull, fpd, dpd, ffl, dfl, pdir;
  logic drive_select_out_a, drive_select_out_b, motor_out_a, motor_out_b, en_a, en_b, sp41, sp39;
  logic [6:0] dpins, latched = 7'h00;
  logic [9:0] base_a, base_b;
  logic [3:0] fifo, upd, ufl;
  logic [2:0] oscs;
  logic [7:0] r [5];
  logic [7:0] msk [5] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h7f};
  logic [31:0] seed = 32'd27;
  int miscompares = 0, check_count = 0, cyc = 0, rd_low = 0, wr_low = 0;
  int rise [2] = '{0, 0};

  scr_host_model hm (.CORE_CLK(clk), .HOST(host), .SD_OUT(sd_out), .SD_OE(sd_oe));
  scr_cfg_bank dut (.CORE_CLK(clk), .RST_N(rst_n), .HOST(host), .SD_OUT(sd_out), .SD_OE(sd_oe),
    .PRT_MODE_LO(mode_lo), .PRT_MODE_HI(mode_hi), .CONFIG_LOCK_BIT(lock), .OSC_CTRL_LO(osc),
    .FIRST_SERIAL_SEL(sel_a), .SECOND_SERIAL_SEL(sel_b), .ADAPTER_DMA_ACK_N(dack_n),
    .ADAPTER_READ_STROBE_N(rs_n), .ADAPTER_WRITE_STROBE_N(ws_n), .ADAPTER_DATA_PINS_OUT(dpins),
    .ADAPTER_DATA_PINS_OE(dpoe), .EXTERNAL_ADAPTER_MODE(xmode), .SERIAL_CLK_OUT(sclk),
    .FIRST_SERIAL_BASE(base_a), .FIRST_SERIAL_EN(en_a), .SECOND_SERIAL_BASE(base_b),
    .SECOND_SERIAL_EN(en_b), .PORTABLE_FLOPPY_ENABLE_IN(pfd), .PORTABLE_EXTERNAL_ENABLE_IN(pext),
    .SHARED_PIN_41(sp41), .SHARED_PIN_39(sp39), .GAME_PORT_DISABLE(gdis),
    .PARALLEL_DIRECTION_STRAP(pfd), .PRINTER_CTRL_DIR(pext), .EPP_REVISION_SELECT(epp),
    .PARALLEL_BIDIR_EN(bidir), .PARALLEL_DIR_INPUT(pdir), .ECP_FIFO_THRESHOLD(fifo),
    .UNIT_POWER_DOWN(upd), .UNIT_FLOAT(ufl), .OSC_SELECT(oscs), .FLOPPY_DOR(dor),
    .DRIVE_SELECT_OUT_A_N(drive_select_out_a), .DRIVE_SELECT_OUT_B_N(drive_select_out_b), .MOTOR_OUT_A_N(motor_out_a),
    .MOTOR_OUT_B_N(motor_out_b), .FLOPPY_PULLUP_EN(pull), .FLOPPY_CTRL_POWER_DOWN(fpd),
    .DISK_IFACE_POWER_DOWN(dpd), .FLOPPY_CTRL_FLOAT(ffl), .DISK_IFACE_FLOAT(dfl));

  always #5 clk = ~clk;

  // Strobe and clock activity is counted, not sampled, so pulse widths are checked exactly.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_low <= rd_low + int'(!rs_n);
    wr_low <= wr_low + int'(!ws_n);
    sclk_q <= sclk;
    for (int i = 0; i < 2; i++) begin
      rise[i] <= rise[i] + int'(sclk[i] && !sclk_q[i]);
    end
    if (dpoe) begin
      latched <= dpins;
    end
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [9:0] sbase(input logic f, input logic [9:0] fv, input logic [1:0] s,
                                       input logic [29:0] t);
    return f ? fv : (s == 2'h3) ? 10'h000 : t[s*10 +: 10];
  endfunction : sbase

  function automatic logic [3:0] drv(input logic four, input logic [7:0] d);
    logic m;
    m = d[4 + d[1:0]];
    if (four) return {!m, !m, d[1:0]};
    if (d[1:0] == 2'h0 && d[4]) return 4'b1010;
    if (d[1:0] == 2'h1 && d[5]) return 4'b0101;
    return 4'hf;
  endfunction : drv

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_fields();
    chk(10'(gdis), 10'(r[1][6]));
    chk(10'(epp), 10'(r[1][5]));
    chk(10'(bidir), 10'(!r[1][7]));
    chk(10'(pdir), 10'(!r[1][7] && pfd && pext));
    chk(base_a, sbase(r[1][3], 10'h2f8, sel_a, {10'h3f8, 10'h3e8, 10'h2e8}));
    chk(10'(en_a), 10'(r[1][3] || sel_a != 2'h3));
    chk(base_b, sbase(r[1][2], 10'h3f8, sel_b, {10'h2f8, 10'h2e8, 10'h3e8}));
    chk(10'(en_b), 10'(r[1][2] || sel_b != 2'h3));
    chk(10'(upd), 10'(r[2][7:4]));
    chk(10'(ufl), 10'(r[2][7:4] & r[2][3:0]));
    chk(10'(fifo), 10'(r[3][3:0]));
    chk(10'(oscs), 10'({r[4][6], osc}));
    chk(10'(pull), 10'(!r[4][4]));
    chk(10'({fpd, dpd}), 10'(r[4][3:2]));
    chk(10'({ffl, dfl}), 10'(r[4][3:2] & r[4][1:0]));
    chk(10'({motor_out_b, motor_out_a, drive_select_out_b, drive_select_out_a}), 10'(drv(r[4][5], dor)));
    chk(10'({sp41, sp39}), r[1][4] ? 10'h3 : 10'({pfd, pext}));
  endtask : chk_fields

  task automatic acc(input logic [9:0] a, input logic rd, input logic dma, input int er,
                     input int ew);
    int b0, b1;
    dack_n <= !dma;
    b0 = rd_low;
    b1 = wr_low;
    hm.io(a, 8'h5a, rd, dma, q, oe);
    dack_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(10'(rd_low - b0), 10'(er));
    chk(10'(wr_low - b1), 10'(ew));
  endtask : acc

  task automatic ser(input logic [7:0] v, input int e0, input int e1);
    int b0, b1;
    hm.cfg(8'h03, v, 1'b0, q, oe);
    r[1] = v;
    repeat (4) @(posedge clk);
    b0 = rise[0];
    b1 = rise[1];
    repeat (156) @(posedge clk);
    chk(10'(rise[0] - b0), 10'(e0));
    chk(10'(rise[1] - b1), 10'(e1));
  endtask : ser

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    int n;
    logic [7:0] d;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    r = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      hm.cfg(8'h02 + 8'(i), 8'h00, 1'b1, q, oe);
      chk(10'(q), 10'(r[i]));
    end
    chk_fields();
    for (int k = 0; k < 30; k++) begin
      n = (k < 5) ? k : int'(rnd() % 32'd5);
      d = (k < 5) ? 8'hff : 8'(rnd());
      {osc, sel_a, sel_b, pfd, pext} <= 8'(rnd());
      dor <= 8'(rnd());
      hm.cfg(8'h02 + 8'(n), d, 1'b0, q, oe);
      r[n] = d & msk[n];
      hm.cfg(8'h02 + 8'(n), 8'h00, 1'b1, q, oe);
      chk(10'(q), 10'(r[n]));
      chk(10'(oe), 10'h001);
      chk_fields();
    end
    lock <= 1'b1;
    hm.cfg(8'h03, ~r[1], 1'b0, q, oe);
    hm.cfg(8'h03, 8'h00, 1'b1, q, oe);
    chk(10'(oe), 10'h000);
    lock <= 1'b0;
    hm.io(scr_pkg::KEY_PORT, 8'h00, 1'b0, 1'b0, q, oe);
    hm.io(scr_pkg::DATA_PORT, ~r[1], 1'b0, 1'b0, q, oe);
    hm.cfg(8'h03, 8'h00, 1'b1, q, oe);
    chk(10'(q), 10'(r[1]));
    hm.cfg(8'h02, 8'h00, 1'b0, q, oe);
    mode_lo <= 2'h2;
    n = rd_low;
    hm.cfg(8'h02, 8'hc0, 1'b0, q, oe);
    repeat (12) @(posedge clk);
    #1;
    chk(10'(rd_low - n), 10'd10);
    chk(10'(latched), 10'h060);
    chk(10'(xmode), 10'h001);
    acc(10'h300, 1'b0, 1'b0, 0, 2);
    acc(10'h304, 1'b1, 1'b0, 2, 0);
    acc(10'h308, 1'b1, 1'b0, 0, 0);
    acc(10'h000, 1'b1, 1'b1, 2, 0);
    acc(10'h000, 1'b0, 1'b1, 0, 2);
    hm.cfg(8'h02, 8'hc1, 1'b0, q, oe);
    repeat (12) @(posedge clk);
    acc(10'h308, 1'b1, 1'b0, 2, 0);
    acc(10'h310, 1'b1, 1'b0, 0, 0);
    mode_hi <= 1'b1;
    acc(10'h300, 1'b0, 1'b0, 0, 0);
    chk(10'(xmode), 10'h000);
    mode_hi <= 1'b0;
    mode_lo <= 2'h0;
    ser(8'h01, 13, 12);
    ser(8'h02, 12, 13);
    chk_fields();
    stop_test();
  end
endmodule : tb_top
